// >>> adc_port_pkg.sv
/*
  shared constants and types for the serial converter readout port.
  assumes a 50 MHz system clock and a free-standing host serial clock.
*/
package adc_port_pkg;

  localparam int CLOCK_PERIOD_NS = 20;
  localparam int CONVERT_TIME_NS = 3300;
  localparam int HOLD_TIME_NS    = 20;
  // least times round up to whole cycles
  localparam int CONVERT_CYCLES  = (CONVERT_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int HOLD_CYCLES     = (HOLD_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  localparam int CODE_BITS   = 12;
  localparam int LEAD_ZEROS  = 4;
  localparam int FRAME_BITS  = 16;
  localparam int POS_BITS    = 5;
  localparam int FIFO_DEPTH  = 16;
  localparam int CNT_BITS    = 8;

  localparam logic [POS_BITS-1:0] POS_FIRST  = 5'h01;
  localparam logic [POS_BITS-1:0] POS_LAST   = 5'h0f;
  localparam logic [POS_BITS-1:0] POS_DONE   = 5'h10;
  localparam logic [POS_BITS-1:0] POS_RESET  = 5'h00;
  localparam logic [CNT_BITS-1:0] CONV_LOAD  = CNT_BITS'(CONVERT_CYCLES - 1);
  localparam logic [CNT_BITS-1:0] HOLD_LOAD  = CNT_BITS'(HOLD_CYCLES - 1);
  localparam logic [CNT_BITS-1:0] CNT_ZERO   = 8'h00;

  typedef logic signed [CODE_BITS-1:0] code_t;

  typedef struct packed {
    logic [LEAD_ZEROS-1:0] lead;
    code_t                 code;
  } frame_t;

  localparam frame_t FRAME_RESET = 16'h0000;

  typedef enum {
    ST_IDLE,
    ST_CONVERT,
    ST_FRAME,
    ST_RELEASE,
    ST_DESELECT
  } port_state_t;

endpackage

// >>> level_sync.sv
/*
  three-stage level synchroniser into the system clock; the output
  changes only once the second and third stages agree.
  assumes the input is a level from another clock or a pin.
*/
module level_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] levelIn,
  output logic      [WIDTH-1:0] levelOut
);

  logic [WIDTH-1:0] stage1_q;
  logic [WIDTH-1:0] stage2_q;
  logic [WIDTH-1:0] stage3_q;
  logic [WIDTH-1:0] out_q;
  logic [WIDTH-1:0] out_d;

  ////////////////////////////////////////////////////////////////////
  always_comb
  begin
    out_d = out_q;
    if (stage2_q == stage3_q)
    begin
      out_d = stage3_q;
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      stage1_q <= '0;
      stage2_q <= '0;
      stage3_q <= '0;
      out_q    <= '0;
    end
    else
    begin
      stage1_q <= levelIn;
      stage2_q <= stage1_q;
      stage3_q <= stage2_q;
      out_q    <= out_d;
    end
  end

  assign levelOut = out_q;

endmodule

// >>> sample_fifo.sv
/*
  synchronous fifo of flip-flops with valid and ready on both sides.
  assumes DEPTH is a power of two.
*/
module sample_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  input  wire logic             clock,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wrPtr_q;
  logic [AW:0]      wrPtr_d;
  logic [AW:0]      rdPtr_q;
  logic [AW:0]      rdPtr_d;
  logic             push;
  logic             pop;

  ////////////////////////////////////////////////////////////////////
  always_comb
  begin
    inReady  = !((wrPtr_q[AW] != rdPtr_q[AW]) && (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]));
    outValid = (wrPtr_q != rdPtr_q);
    outData  = mem_q[rdPtr_q[AW-1:0]];
    push     = inValid && inReady;
    pop      = outValid && outReady;
    wrPtr_d  = push ? wrPtr_q + 1'b1 : wrPtr_q;
    rdPtr_d  = pop ? rdPtr_q + 1'b1 : rdPtr_q;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end
    else
    begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
    end
  end

  always_ff @(posedge clock)
  begin
    if (push)
    begin
      mem_q[wrPtr_q[AW-1:0]] <= inData;
    end
  end

endmodule

// >>> serial_adc_readout_port.sv
/*
  control and serial readout of a 12-bit converter: conversion start on
  the shared select pin, 16-bit frames shifted out on host clock edges.
  assumes converted codes arrive as a stream on the system clock, and
  the host serial clock is the link clock, active on its falling edge.
*/

// Function
// - mode 0: start falling edge holds, converts
// - mode 1: select low converts and frames
// - mode 1: host serial clock paces conversion
// - each serial clock fall shifts next bit
// - frame: four zeros, twelve bits, msb first
// - after sixteenth fall hold, then release
// - result coded in two's complement
module serial_adc_readout_port (
  input  wire logic                 clock,
  input  wire logic                 sys_rst,
  input  wire logic                 serialClk,
  input  wire logic                 select_or_convert_pin,
  input  wire logic                 mode1Select,
  input  wire adc_port_pkg::code_t  sampleCode,
  input  wire logic                 sampleValid,
  output logic                      sampleReady,
  output logic                      serial_result_out,
  output logic                      serialResultOe,
  output logic                      holdActive,
  output logic                      frameBusy
);
  import adc_port_pkg::*;

  function automatic logic [POS_BITS-1:0] binToGray(input logic [POS_BITS-1:0] b);
    binToGray = b ^ (b >> 1);
  endfunction

  function automatic logic [POS_BITS-1:0] grayToBin(input logic [POS_BITS-1:0] g);
    logic [POS_BITS-1:0] b;
    b = '0;
    b[POS_BITS-1] = g[POS_BITS-1];
    for (int i = POS_BITS - 2; i >= 0; i--)
    begin
      b[i] = g[i] ^ b[i+1];
    end
    grayToBin = b;
  endfunction

  function automatic frame_t makeFrame(input code_t c);
    frame_t f;
    f.lead = '0;
    f.code = c;
    makeFrame = f;
  endfunction

  function automatic logic [POS_BITS-1:0] framePos(input logic [POS_BITS-1:0] cnt,
                                                   input logic [POS_BITS-1:0] base);
    framePos = cnt - base;
  endfunction

  logic [1:0]           pinsSync;
  logic                 selLevel;
  logic                 modeOne;
  logic                 convert_start_n;
  logic                 startFall;
  logic [POS_BITS-1:0]  grayInSys;
  logic [POS_BITS-1:0]  linkCountSys;
  logic [POS_BITS-1:0]  sysPos;
  code_t                fifoCode;
  logic                 fifoValid;
  logic                 fifoPop;

  port_state_t          state_q;
  port_state_t          state_d;
  logic                 prevSel_q;
  logic                 prevSel_d;
  logic [CNT_BITS-1:0]  cnt_q;
  logic [CNT_BITS-1:0]  cnt_d;
  frame_t               frameWord_q;
  frame_t               frameWord_d;
  code_t                lastCode_q;
  code_t                lastCode_d;
  logic [POS_BITS-1:0]  base_q;
  logic [POS_BITS-1:0]  base_d;
  logic                 oe_q;
  logic                 oe_d;
  logic                 hold_q;
  logic                 hold_d;
  logic                 mask_q;
  logic                 mask_d;
  logic                 busy_q;
  logic                 busy_d;

  logic                 lrst1_q;
  logic                 lrst2_q;
  logic                 lrst3_q;
  logic                 linkRst_q;
  logic                 linkRst_d;
  logic [POS_BITS-1:0]  linkCnt_q;
  logic [POS_BITS-1:0]  linkCnt_d;
  logic [POS_BITS-1:0]  linkGray_q;
  logic [POS_BITS-1:0]  linkGray_d;
  logic                 dataBit_q;
  logic                 dataBit_d;
  logic [POS_BITS-1:0]  linkPos;

  ////////////////////////////////////////////////////////////////////
  // pin and count crossings into the system clock
  level_sync #(
    .WIDTH (2)
  ) u_pin_sync (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .levelIn  ({select_or_convert_pin, mode1Select}),
    .levelOut (pinsSync)
  );

  level_sync #(
    .WIDTH (POS_BITS)
  ) u_count_sync (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .levelIn  (linkGray_q),
    .levelOut (grayInSys)
  );

  assign selLevel        = pinsSync[1];
  assign modeOne         = pinsSync[0];
  assign convert_start_n = selLevel;
  assign startFall       = prevSel_q && !convert_start_n;
  assign linkCountSys    = grayToBin(grayInSys);
  assign sysPos          = framePos(linkCountSys, base_q);

  ////////////////////////////////////////////////////////////////////
  // converted codes wait here until a conversion takes one
  sample_fifo #(
    .WIDTH (CODE_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .inData   (sampleCode),
    .inValid  (sampleValid),
    .inReady  (sampleReady),
    .outData  (fifoCode),
    .outValid (fifoValid),
    .outReady (fifoPop)
  );

  ////////////////////////////////////////////////////////////////////
  // conversion and frame control
  always_comb
  begin
    state_d     = state_q;
    prevSel_d   = selLevel;
    cnt_d       = cnt_q;
    frameWord_d = frameWord_q;
    lastCode_d  = lastCode_q;
    base_d      = base_q;
    oe_d        = oe_q;
    hold_d      = hold_q;
    fifoPop     = 1'b0;
    case (state_q)
      ST_IDLE:
      begin
        if (startFall)
        begin
          hold_d  = 1'b1;
          fifoPop = fifoValid;
          if (fifoValid)
          begin
            frameWord_d = makeFrame(fifoCode);
            lastCode_d  = fifoCode;
          end
          else
          begin
            frameWord_d = makeFrame(lastCode_q);
          end
          if (modeOne)
          begin
            base_d  = linkCountSys;
            oe_d    = 1'b1;
            state_d = ST_FRAME;
          end
          else
          begin
            cnt_d   = CONV_LOAD;
            state_d = ST_CONVERT;
          end
        end
      end
      ST_CONVERT:
      begin
        if (cnt_q == CNT_ZERO)
        begin
          hold_d  = 1'b0;
          base_d  = linkCountSys;
          oe_d    = 1'b1;
          state_d = ST_FRAME;
        end
        else
        begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      ST_FRAME:
      begin
        if (modeOne && selLevel)
        begin
          oe_d    = 1'b0;
          hold_d  = 1'b0;
          state_d = ST_IDLE;
        end
        else if (sysPos >= POS_DONE)
        begin
          hold_d  = 1'b0;
          cnt_d   = HOLD_LOAD;
          state_d = ST_RELEASE;
        end
      end
      ST_RELEASE:
      begin
        if (cnt_q == CNT_ZERO)
        begin
          oe_d    = 1'b0;
          state_d = modeOne ? ST_DESELECT : ST_IDLE;
        end
        else
        begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      ST_DESELECT:
      begin
        if (selLevel)
        begin
          state_d = ST_IDLE;
        end
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
    busy_d = (state_d != ST_IDLE);
    // the leading zero shows until the first fall is seen here
    mask_d = !(((state_q == ST_FRAME) || (state_q == ST_RELEASE)) && (sysPos != POS_RESET));
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      state_q     <= ST_IDLE;
      prevSel_q   <= 1'b0;
      cnt_q       <= CNT_ZERO;
      frameWord_q <= FRAME_RESET;
      lastCode_q  <= '0;
      base_q      <= POS_RESET;
      oe_q        <= 1'b0;
      hold_q      <= 1'b0;
      mask_q      <= 1'b1;
      busy_q      <= 1'b0;
    end
    else
    begin
      state_q     <= state_d;
      prevSel_q   <= prevSel_d;
      cnt_q       <= cnt_d;
      frameWord_q <= frameWord_d;
      lastCode_q  <= lastCode_d;
      base_q      <= base_d;
      oe_q        <= oe_d;
      hold_q      <= hold_d;
      mask_q      <= mask_d;
      busy_q      <= busy_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // link side on falling serial clock edges; frame word and base are
  // held still by the system side while a frame is open
  assign linkPos = framePos(linkCnt_d, base_q);

  always_comb
  begin
    linkRst_d = linkRst_q;
    if (lrst2_q == lrst3_q)
    begin
      linkRst_d = lrst3_q;
    end
    linkCnt_d = linkCnt_q + 1'b1;
    dataBit_d = dataBit_q;
    if ((linkPos >= POS_FIRST) && (linkPos <= POS_LAST))
    begin
      dataBit_d = frameWord_q[4'(POS_LAST - linkPos)];
    end
    if (linkRst_q)
    begin
      linkCnt_d = POS_RESET;
      dataBit_d = 1'b0;
    end
    linkGray_d = binToGray(linkCnt_d);
  end

  always_ff @(negedge serialClk)
  begin
    lrst1_q    <= sys_rst;
    lrst2_q    <= lrst1_q;
    lrst3_q    <= lrst2_q;
    linkRst_q  <= linkRst_d;
    linkCnt_q  <= linkCnt_d;
    linkGray_q <= linkGray_d;
    dataBit_q  <= dataBit_d;
  end

  ////////////////////////////////////////////////////////////////////
  assign serial_result_out = dataBit_q && !mask_q;
  assign serialResultOe    = oe_q;
  assign holdActive        = hold_q;
  assign frameBusy         = busy_q;

endmodule

// >>> serial_adc_readout_port_sva.sv
/*
  concurrent checks on the readout port's pins.
  assumes it is bound to the top module and sees its ports only.
*/
module serial_adc_readout_port_sva
  import adc_port_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic serialClk,
  input wire logic select_or_convert_pin,
  input wire logic mode1Select,
  input wire logic serial_result_out,
  input wire logic serialResultOe,
  input wire logic holdActive,
  input wire logic frameBusy
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [4:0] fallCntQ;
  logic [8:0] holdCntD;
  logic [8:0] holdCntQ;
  default clocking @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////
  // falls within a driven frame
  always_ff @(negedge serialClk or negedge serialResultOe)
    if (!serialResultOe) fallCntQ <= 5'h00;
    else fallCntQ <= fallCntQ + 5'h01;
  assign holdCntD = holdActive ? holdCntQ + 9'h001 : 9'h000;
  always_ff @(posedge clock)
    holdCntQ <= holdCntD;
  ////////////////////////////////////////
  AST_START_HOLDS: assert property (
    !mode1Select && !frameBusy && $fell(select_or_convert_pin) |-> ##[1:8] holdActive)
    else $error("no hold after start edge");
  AST_CONVERT_TIME: assert property (
    !mode1Select && $fell(holdActive) |->
    holdCntQ >= 9'(CONVERT_CYCLES - 1) && holdCntQ <= 9'(CONVERT_CYCLES + 1))
    else $error("conversion length wrong");
  AST_DRIVE_AT_END: assert property (
    !mode1Select && $fell(holdActive) |-> serialResultOe)
    else $error("output not driven after conversion");
  AST_SELECT_FRAMES: assert property (
    mode1Select && !frameBusy && $fell(select_or_convert_pin) |->
    ##[1:8] (serialResultOe && holdActive))
    else $error("select did not open frame");
  AST_DESELECT_DROPS: assert property (
    mode1Select && $rose(select_or_convert_pin) |-> ##8 !serialResultOe)
    else $error("output driven after deselect");
  AST_LEAD_ZEROS: assert property (
    serialResultOe && fallCntQ < 5'h04 |-> !serial_result_out)
    else $error("leading bit not zero");
  AST_RELEASE_16: assert property (
    !mode1Select && $fell(serialResultOe) |-> $past(fallCntQ) == 5'h10)
    else $error("release not after sixteen falls");
  AST_PACED_BY_CLK: assert property (
    mode1Select && !select_or_convert_pin && $fell(holdActive) |-> fallCntQ == 5'h10)
    else $error("conversion end not at sixteenth fall");
  AST_IDLE_RELEASED: assert property (
    !frameBusy |-> !serialResultOe)
    else $error("output driven while idle");
endmodule

bind serial_adc_readout_port serial_adc_readout_port_sva serial_adc_readout_port_sva_i (
  .clock                (clock),
  .sys_rst              (sys_rst),
  .serialClk            (serialClk),
  .select_or_convert_pin(select_or_convert_pin),
  .mode1Select          (mode1Select),
  .serial_result_out    (serial_result_out),
  .serialResultOe       (serialResultOe),
  .holdActive           (holdActive),
  .frameBusy            (frameBusy)
);

// >>> host_link_model.sv
/*
  host side of the link: select pin, serial clock, frame capture.
  assumes frames of 16 bits, msb first, launched on falling edges.
*/
module host_link_model (
  input  wire logic freeRun,
  input  wire logic serial_result_out,
  input  wire logic serialResultOe,
  output logic      serialClk,
  output logic      select_or_convert_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  logic heldBit;
  logic lineLevel;
  initial
  begin
    serialClk = 1'b0;
    select_or_convert_pin = 1'b1;
  end
  ////////////////////////////////////////
  // released line shows the inverse of its last level
  always @(negedge serialResultOe)
    heldBit = ~serial_result_out;
  assign lineLevel = serialResultOe ? serial_result_out : heldBit;
  always #16 if (freeRun) serialClk = ~serialClk;
  always @(negedge freeRun) #20 serialClk = 1'b0;
  ////////////////////////////////////////
  task automatic read_frame(input logic m1, input int falls, output logic [15:0] word);
    word = 16'h0000;
    select_or_convert_pin = 1'b0;
    for (int i = 0; i < 400 && serialResultOe !== 1'b1; i++) #20;
    if (!m1) select_or_convert_pin = 1'b1;
    #200;
    for (int i = 0; i < falls; i++)
    begin
      #16 serialClk = 1'b1;
      #8 word = {word[14:0], lineLevel};
      #8 serialClk = 1'b0;
    end
    #100;
    select_or_convert_pin = 1'b1;
    #200;
  endtask
endmodule

// >>> test_serial_adc_readout_port.sv
/*
  self-checking bench for the serial readout port in both modes.
  assumes the host model and the checker are compiled alongside.
*/
module test_serial_adc_readout_port;
  timeunit 1ns;
  timeprecision 100ps;
  import adc_port_pkg::*;
  logic        clock;
  logic        sys_rst;
  logic        freeRun;
  logic        mode1Select;
  code_t       sampleCode;
  logic        sampleValid;
  logic        sampleReady;
  logic        serialClk;
  logic        select_or_convert_pin;
  logic        serial_result_out;
  logic        serialResultOe;
  logic        holdActive;
  logic        frameBusy;
  logic [15:0] word;
  int          error_cnt;
  int          check_count;

  serial_adc_readout_port serial_adc_readout_port_i (
    .clock                (clock),
    .sys_rst              (sys_rst),
    .serialClk            (serialClk),
    .select_or_convert_pin(select_or_convert_pin),
    .mode1Select          (mode1Select),
    .sampleCode           (sampleCode),
    .sampleValid          (sampleValid),
    .sampleReady          (sampleReady),
    .serial_result_out    (serial_result_out),
    .serialResultOe       (serialResultOe),
    .holdActive           (holdActive),
    .frameBusy            (frameBusy)
  );
  host_link_model host_link_model_i (
    .freeRun              (freeRun),
    .serial_result_out    (serial_result_out),
    .serialResultOe       (serialResultOe),
    .serialClk            (serialClk),
    .select_or_convert_pin(select_or_convert_pin)
  );
  ////////////////////////////////////////
  always #10 clock = ~clock;

  function automatic code_t code_of(input int i);
    return 12'h800 ^ 12'(i * 273);
  endfunction

  task automatic check(input logic [15:0] act, input logic [15:0] exp);
    check_count++;
    if (act !== exp)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t got %h exp %h", $time, act, exp);
    end
  endtask

  task automatic do_reset(input logic m1);
    @(posedge clock);
    #2;
    sys_rst = 1'b1;
    mode1Select = m1;
    freeRun = 1'b1;
    repeat (8) @(posedge clock);
    #2;
    sys_rst = 1'b0;
    // link reset only lets go on serial clock falls
    repeat (10) @(posedge clock);
    #2;
    freeRun = 1'b0;
    repeat (8) @(posedge clock);
  endtask

  task automatic push_words(input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clock);
      #2;
      sampleValid = 1'b1;
      sampleCode = code_of(i);
    end
    @(posedge clock);
    #2;
    sampleValid = 1'b0;
  endtask

  task automatic frame(input logic m1, input int falls, input code_t c);
    host_link_model_i.read_frame(m1, falls, word);
    if (falls == 16) check(word, {4'h0, c});
    for (int i = 0; i < 60 && frameBusy !== 1'b0; i++) #20;
    check({15'h0, serialResultOe}, 16'h0000);
    check({15'h0, frameBusy}, 16'h0000);
    check({15'h0, holdActive}, 16'h0000);
  endtask
  ////////////////////////////////////////
  task automatic test_mode0();
    do_reset(1'b0);
    push_words(16);
    check({15'h0, sampleReady}, 16'h0000);
    for (int i = 0; i < 16; i++) frame(1'b0, 16, code_of(i));
    frame(1'b0, 16, code_of(15));
    check({15'h0, sampleReady}, 16'h0001);
    $display("mode 0 test done");
  endtask

  task automatic test_mode1();
    do_reset(1'b1);
    push_words(4);
    for (int i = 0; i < 4; i++) frame(1'b1, 16, code_of(i));
    frame(1'b1, 5, code_of(3));
    frame(1'b1, 16, code_of(3));
    $display("mode 1 test done");
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  ////////////////////////////////////////
  initial
  begin
    clock = 1'b0;
    sys_rst = 1'b1;
    freeRun = 1'b1;
    mode1Select = 1'b0;
    sampleCode = 12'h000;
    sampleValid = 1'b0;
    error_cnt = 0;
    check_count = 0;
    test_mode0();
    test_mode1();
    print_verdict();
  end

  initial
  begin
    #400000;
    error_cnt++;
    $display("watchdog expired");
    print_verdict();
  end
endmodule
